//--- hdl/pllsp_defs.svh
`ifndef PLLSP_DEFS_SVH
`define PLLSP_DEFS_SVH
// ****************************************
// word layout
// ****************************************
`define PLLSP_WORD_W 21
`define PLLSP_SEL_REF 2'h0
`define PLLSP_SEL_FB 2'h1
`define PLLSP_SEL_FUNC 2'h2
`define PLLSP_SEL_INIT 2'h3
`define PLLSP_LDP_BIT 20
`define PLLSP_RDIV_HI 15
`define PLLSP_RDIV_LO 2
`define PLLSP_GAIN_BIT 20
`define PLLSP_MAIN_HI 19
`define PLLSP_MAIN_LO 7
`define PLLSP_SWAL_HI 6
`define PLLSP_SWAL_LO 2
`define PLLSP_SLEEP_HI_BIT 19
`define PLLSP_OBS_HI 6
`define PLLSP_OBS_LO 4
`define PLLSP_SLEEP_LO_BIT 3
`define PLLSP_CLEAR_BIT 2
`define PLLSP_SENSE_BIT 7
`define PLLSP_FLOAT_BIT 8
`define PLLSP_REF_RST 21'h000004
`define PLLSP_FB_RST 21'h000181
`define PLLSP_FUNC_RST 21'h000002
`define PLLSP_INIT_RST 21'h000003
// ****************************************
// timing
// ****************************************
`define PLLSP_CLK_NS 4
`define PLLSP_ABL_NS 3
`define PLLSP_ABL_CYC ((`PLLSP_ABL_NS + `PLLSP_CLK_NS - 1) / `PLLSP_CLK_NS)
`define PLLSP_LOCK_IN_NS 15
`define PLLSP_LOCK_IN_CYC (`PLLSP_LOCK_IN_NS / `PLLSP_CLK_NS)
`define PLLSP_LOCK_OUT_NS 25
`define PLLSP_LOCK_OUT_CYC (`PLLSP_LOCK_OUT_NS / `PLLSP_CLK_NS)
`define PLLSP_LOCK_CNT 2'h3
// ****************************************
// host wishbone map
// ****************************************
`define PLLSP_ADR_DATA 4'h0
`define PLLSP_ADR_CTRL 4'h4
`define PLLSP_ADR_STAT 4'h8
`define PLLSP_ADR_MASK 4'hC
`define PLLSP_DIV_DEFAULT 8'h04
`endif

//--- hdl/pllsp_pkg.sv
package pllsp_pkg;
  typedef enum logic [1:0] {PLLSP_IDLE, PLLSP_LOW, PLLSP_HIGH, PLLSP_LOAD} pllsp_state_e;
  typedef logic [20:0] pllsp_word_t;
endpackage

//--- hdl/pllsp_if.sv
interface pllsp_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  logic chip_enable;
  logic observe_out;
  logic observe_oe_n;
  modport host (output ser_clk, output ser_data, output load_strobe, output chip_enable,
    input observe_out, input observe_oe_n);
  modport dev (input ser_clk, input ser_data, input load_strobe, input chip_enable,
    output observe_out, output observe_oe_n);
endinterface

//--- hdl/pllsp_host.sv
`include "pllsp_defs.svh"
module pllsp_host #(
  parameter int DIV_W = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  pllsp_if.host link
);
  // ****************************************
  // registers
  // ****************************************
  logic [20:0] data_reg;
  logic [DIV_W-1:0] div_reg;
  logic ce_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [20:0] shift_reg;
  logic [4:0] bit_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic lock_s1_reg;
  logic lock_s2_reg;
  logic lock_d_reg;
  pllsp_pkg::pllsp_state_e st_reg;
  logic wr;
  logic rd;
  logic tick;
  logic done;
  // write commits on the edge at which the master sees ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign tick = cnt_reg == '0;
  assign done = st_reg == pllsp_pkg::PLLSP_LOAD && tick;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_reg <= '0;
      div_reg <= DIV_W'(`PLLSP_DIV_DEFAULT);
      ce_reg <= 1'b0;
      mask_reg <= '0;
    end else if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        `PLLSP_ADR_DATA: data_reg <= wb_dat_i[20:0];
        `PLLSP_ADR_CTRL: begin
          ce_reg <= wb_dat_i[0];
          div_reg <= wb_dat_i[8 +: DIV_W];
        end
        `PLLSP_ADR_MASK: mask_reg <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_dat_o <= '0;
    end else begin
      case (wb_adr_i)
        `PLLSP_ADR_DATA: wb_dat_o <= {11'h000, data_reg};
        `PLLSP_ADR_CTRL: wb_dat_o <= 32'(div_reg) << 8 | {31'h0, ce_reg};
        `PLLSP_ADR_STAT: wb_dat_o <= {29'h0, st_reg != pllsp_pkg::PLLSP_IDLE, stat_reg};
        `PLLSP_ADR_MASK: wb_dat_o <= {30'h0, mask_reg};
        default: wb_dat_o <= '0;
      endcase
    end
  end
  // status: bit0 word sent, bit1 observe edge; set wins over read clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_reg <= '0;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
      lock_d_reg <= 1'b0;
    end else begin
      lock_s1_reg <= link.observe_out;
      lock_s2_reg <= lock_s1_reg;
      lock_d_reg <= lock_s2_reg;
      stat_reg <= ((rd && wb_adr_i == `PLLSP_ADR_STAT) ? 2'b00 : stat_reg)
        | {lock_s2_reg != lock_d_reg, done};
    end
  end
  assign irq = |(stat_reg & mask_reg);
  // ****************************************
  // serial engine
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst || tick) begin
      cnt_reg <= div_reg;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= pllsp_pkg::PLLSP_IDLE;
      shift_reg <= '0;
      bit_reg <= '0;
      link.ser_clk <= 1'b0;
      link.ser_data <= 1'b0;
      link.load_strobe <= 1'b0;
    end else begin
      case (st_reg)
        pllsp_pkg::PLLSP_IDLE: begin
          link.load_strobe <= 1'b0;
          if (wr && wb_adr_i == `PLLSP_ADR_DATA) begin
            shift_reg <= wb_dat_i[20:0];
            bit_reg <= 5'd21;
            st_reg <= pllsp_pkg::PLLSP_LOW;
          end
        end
        pllsp_pkg::PLLSP_LOW: if (tick) begin
          link.ser_clk <= 1'b0;
          link.ser_data <= shift_reg[20];
          shift_reg <= {shift_reg[19:0], 1'b0};
          st_reg <= pllsp_pkg::PLLSP_HIGH;
        end
        pllsp_pkg::PLLSP_HIGH: if (tick) begin
          link.ser_clk <= 1'b1;
          bit_reg <= bit_reg - 1'b1;
          st_reg <= (bit_reg == 5'd1) ? pllsp_pkg::PLLSP_LOAD : pllsp_pkg::PLLSP_LOW;
        end
        pllsp_pkg::PLLSP_LOAD: if (tick) begin
          link.ser_clk <= 1'b0;
          link.load_strobe <= 1'b1;
          st_reg <= pllsp_pkg::PLLSP_IDLE;
        end
        default: st_reg <= pllsp_pkg::PLLSP_IDLE;
      endcase
    end
  end
  assign link.chip_enable = ce_reg;
endmodule

//--- hdl/pllsp_dev.sv
// Function
// - feedback ratio is modulus times main plus swallow
// - prescaler 8/9 or 32/33 from 4/5 core
// - host keeps prescaler output within counter rate
// - main counter 13 bits, 3 to 8191
// - swallow counter 5 bits, 0 to 31
// - reference divider 14 bits, 1 to 16383
// - detector up/down with fixed anti-backlash pulse
// - observe select field picks monitor source
// - lock sets after three small-error cycles
// - lock clears on error above 25 ns
// - analog lock is open-drain low pulses
// - shift 21 bits msb first on clock rise
// - load strobe rise copies word to latch
// - low two bits pick one of four latches; code 3 loads both the init and function latches
// - reference latch field layout
// - feedback latch field layout
// - function latch field layout
// - chip enable low powers down, floats pump
`include "pllsp_defs.svh"
module pllsp_dev #(
  parameter bit BIG_PRESCALER = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ref_in,
  input wire logic rf_in,
  output logic pump_up,
  output logic pump_dn,
  output logic pump_oe_n,
  output logic powered,
  output logic lock_detect,
  output logic [20:0] ref_divider_latch,
  output logic [20:0] feedback_divider_latch,
  output logic [20:0] function_control_latch,
  pllsp_if.dev link
);
  // ****************************************
  // serial port
  // ****************************************
  pllsp_pkg::pllsp_word_t shift_reg;
  logic clk_d_reg;
  logic le_d_reg;
  logic [20:0] init_reg;
  logic load_pulse;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_d_reg <= 1'b0;
      le_d_reg <= 1'b0;
      shift_reg <= '0;
    end else begin
      clk_d_reg <= link.ser_clk;
      le_d_reg <= link.load_strobe;
      if (link.ser_clk && !clk_d_reg) begin
        shift_reg <= {shift_reg[19:0], link.ser_data};
      end
    end
  end
  assign load_pulse = link.load_strobe && !le_d_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ref_divider_latch <= `PLLSP_REF_RST;
      feedback_divider_latch <= `PLLSP_FB_RST;
      function_control_latch <= `PLLSP_FUNC_RST;
      init_reg <= `PLLSP_INIT_RST;
    end else if (load_pulse) begin
      case (shift_reg[1:0])
        `PLLSP_SEL_REF: ref_divider_latch <= shift_reg;
        `PLLSP_SEL_FB: feedback_divider_latch <= shift_reg;
        `PLLSP_SEL_FUNC: function_control_latch <= shift_reg;
        default: begin
          init_reg <= shift_reg;
          function_control_latch <= shift_reg;
        end
      endcase
    end
  end
  // ****************************************
  // fields
  // ****************************************
  // field extraction
  logic [13:0] r_val;
  logic [12:0] b_val;
  logic [4:0] a_val;
  logic [2:0] obs_sel;
  logic cnt_clear;
  logic lock_precision_sel;
  assign r_val = ref_divider_latch[`PLLSP_RDIV_HI:`PLLSP_RDIV_LO];
  assign lock_precision_sel = ref_divider_latch[`PLLSP_LDP_BIT];
  assign b_val = feedback_divider_latch[`PLLSP_MAIN_HI:`PLLSP_MAIN_LO];
  assign a_val = feedback_divider_latch[`PLLSP_SWAL_HI:`PLLSP_SWAL_LO];
  assign obs_sel = function_control_latch[`PLLSP_OBS_HI:`PLLSP_OBS_LO];
  assign powered = link.chip_enable && !function_control_latch[`PLLSP_SLEEP_LO_BIT];
  assign cnt_clear = srst || !powered || function_control_latch[`PLLSP_CLEAR_BIT];
  // ****************************************
  // dividers, rf_in and ref_in are one-cycle enables
  // ****************************************
  logic [13:0] r_cnt;
  logic r_tick;
  always_ff @(posedge clk_sys) begin
    if (cnt_clear) begin
      r_cnt <= '0;
    end else if (ref_in) begin
      r_cnt <= (r_cnt + 14'd1 >= r_val) ? 14'd0 : r_cnt + 14'd1;
    end
  end
  assign r_tick = ref_in && (r_cnt + 14'd1 >= r_val);
  logic [2:0] core_cnt;
  logic [2:0] ext_cnt;
  logic modsel;
  logic p_tick;
  logic core_wrap;
  logic [2:0] ext_last;
  assign ext_last = BIG_PRESCALER ? 3'd7 : 3'd1;
  assign core_wrap = core_cnt == ((modsel && ext_cnt == ext_last) ? 3'd4 : 3'd3);
  assign p_tick = rf_in && core_wrap && ext_cnt == ext_last;
  always_ff @(posedge clk_sys) begin
    if (cnt_clear) begin
      core_cnt <= '0;
      ext_cnt <= '0;
    end else if (rf_in) begin
      core_cnt <= core_wrap ? 3'd0 : core_cnt + 3'd1;
      if (core_wrap) begin
        ext_cnt <= (ext_cnt == ext_last) ? 3'd0 : ext_cnt + 3'd1;
      end
    end
  end
  logic [12:0] b_cnt;
  logic [4:0] a_cnt;
  logic n_tick;
  assign modsel = a_cnt != a_val;
  assign n_tick = p_tick && (b_cnt + 13'd1 >= b_val);
  always_ff @(posedge clk_sys) begin
    if (cnt_clear) begin
      b_cnt <= '0;
      a_cnt <= '0;
    end else if (p_tick) begin
      if (n_tick) begin
        b_cnt <= '0;
        a_cnt <= '0;
      end else begin
        b_cnt <= b_cnt + 13'd1;
        if (modsel) begin
          a_cnt <= a_cnt + 5'd1;
        end
      end
    end
  end
  // ****************************************
  // detector
  // ****************************************
  logic up_reg;
  logic dn_reg;
  logic [1:0] abl_cnt;
  logic r_ev;
  logic n_ev;
  logic sense;
  assign sense = function_control_latch[`PLLSP_SENSE_BIT];
  assign r_ev = sense ? r_tick : n_tick;
  assign n_ev = sense ? n_tick : r_tick;
  always_ff @(posedge clk_sys) begin
    if (cnt_clear) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      abl_cnt <= '0;
    end else if (abl_cnt != 2'd0) begin
      abl_cnt <= abl_cnt - 2'd1;
      if (abl_cnt == 2'd1) begin
        up_reg <= 1'b0;
        dn_reg <= 1'b0;
      end
    end else begin
      up_reg <= up_reg | r_ev;
      dn_reg <= dn_reg | n_ev;
      if ((up_reg | r_ev) && (dn_reg | n_ev)) begin
        abl_cnt <= 2'(`PLLSP_ABL_CYC);
      end
    end
  end
  assign pump_up = up_reg && !function_control_latch[`PLLSP_FLOAT_BIT];
  assign pump_dn = dn_reg && !function_control_latch[`PLLSP_FLOAT_BIT];
  assign pump_oe_n = !powered || function_control_latch[`PLLSP_FLOAT_BIT];
  // ****************************************
  // lock detect
  // ****************************************
  logic [7:0] err_cnt;
  logic [7:0] err_now;
  logic [1:0] good_cnt;
  logic busy;
  logic pd_done;
  assign busy = up_reg ^ dn_reg;
  // cycle ends when both edges are in; a zero-error cycle never shows busy
  assign pd_done = abl_cnt == 2'd0 && (up_reg | r_ev) && (dn_reg | n_ev);
  assign err_now = (busy && err_cnt != 8'hFF) ? err_cnt + 8'd1 : err_cnt;
  always_ff @(posedge clk_sys) begin
    if (cnt_clear) begin
      err_cnt <= '0;
      good_cnt <= '0;
      lock_detect <= 1'b0;
    end else if (pd_done) begin
      err_cnt <= '0;
      if (err_now < 8'(`PLLSP_LOCK_IN_CYC)) begin
        good_cnt <= (good_cnt == `PLLSP_LOCK_CNT) ? good_cnt : good_cnt + 2'd1;
        if (good_cnt + 2'd1 >= `PLLSP_LOCK_CNT) begin
          lock_detect <= 1'b1;
        end
      end else begin
        good_cnt <= '0;
      end
      if (err_now > 8'(`PLLSP_LOCK_OUT_CYC)) begin
        lock_detect <= 1'b0;
      end
    end else if (busy) begin
      err_cnt <= err_now;
    end
  end
  // ****************************************
  // observe output
  // ****************************************
  // monitor source mux
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link.observe_out <= 1'b0;
      link.observe_oe_n <= 1'b1;
    end else begin
      link.observe_oe_n <= 1'b0;
      case (obs_sel)
        3'h0: link.observe_out <= 1'b0;
        3'h1: link.observe_out <= lock_detect;
        3'h2: link.observe_out <= n_tick;
        3'h3: link.observe_out <= 1'b1;
        3'h4: link.observe_out <= r_tick;
        3'h5: begin
          link.observe_out <= 1'b0;
          link.observe_oe_n <= !busy;
        end
        3'h6: link.observe_out <= lock_precision_sel;
        default: link.observe_out <= 1'b0;
      endcase
    end
  end
endmodule

//--- testbench/pllsp_props.sv
module pllsp_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic observe_out,
  input wire logic observe_oe_n
);
  logic [4:0] rise_cnt_reg;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ****************************************
  // serial clock rises counted per frame
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rise_cnt_reg <= 5'h00;
    end else if (load_strobe) begin
      rise_cnt_reg <= 5'h00;
    end else if ($rose(ser_clk)) begin
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
    end
  end
  a_reset_idle: assert property ($fell(srst) |-> !ser_clk && !load_strobe && !chip_enable && observe_oe_n)
    else $error("link not idle after reset");
  a_frame_bits: assert property ($rose(load_strobe) |-> rise_cnt_reg == 5'h15)
    else $error("frame without 21 clock rises");
  a_strobe_clk_low: assert property (load_strobe |-> !ser_clk)
    else $error("serial clock high during load strobe");
  a_strobe_width: assert property ($rose(load_strobe) |=> !load_strobe)
    else $error("load strobe not a single pulse");
  a_strobe_bounded: assert property ($rose(load_strobe) |-> ##[5:40] !load_strobe)
    else $error("load strobe stuck high");
  a_clk_high_hold: assert property ($rose(ser_clk) |=> ser_clk[*4])
    else $error("serial clock high phase too short");
  a_clk_low_hold: assert property ($fell(ser_clk) |=> (!ser_clk)[*4])
    else $error("serial clock low phase too short");
  a_data_stable: assert property (ser_clk |-> $stable(ser_data))
    else $error("serial data moved while clock high");
endmodule

//--- testbench/pll_divider_serial_program_tb.sv
`include "pllsp_defs.svh"
module pll_divider_serial_program_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, srst, wb_we, wb_cyc, wb_stb, wb_ack, irq, ref_in, rf_in;
  logic pump_up, pump_dn, pump_oe_n, powered, lock_detect;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_dat_o;
  pllsp_pkg::pllsp_word_t ref_l, fb_l, fn_l, exp_ref, exp_fb, exp_fn;
  int fails, compares;
  pllsp_if pllsp_if_i ();
  pllsp_host pllsp_host_i (.clk_sys(clk_sys), .srst(srst), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .irq(irq),
    .link(pllsp_if_i));
  pllsp_dev #(.BIG_PRESCALER(1'b1)) pllsp_dev_i (.clk_sys(clk_sys), .srst(srst), .ref_in(ref_in), .rf_in(rf_in),
    .pump_up(pump_up), .pump_dn(pump_dn), .pump_oe_n(pump_oe_n), .powered(powered), .lock_detect(lock_detect),
    .ref_divider_latch(ref_l), .feedback_divider_latch(fb_l), .function_control_latch(fn_l), .link(pllsp_if_i));
  pllsp_props pllsp_props_i (.clk_sys(clk_sys), .srst(srst), .ser_clk(pllsp_if_i.ser_clk),
    .ser_data(pllsp_if_i.ser_data), .load_strobe(pllsp_if_i.load_strobe), .chip_enable(pllsp_if_i.chip_enable),
    .observe_out(pllsp_if_i.observe_out), .observe_oe_n(pllsp_if_i.observe_oe_n));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_sys);
    wb_adr <= a;
    wb_we <= we;
    wb_dat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    for (i = 0; i < 64 && wb_ack !== 1'b1; i++) @(posedge clk_sys);
    if (i == 64) begin
      fails++;
      stop_test();
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  function automatic pllsp_pkg::pllsp_word_t fw(input logic [2:0] obs, input logic clr);
    return {14'h0000, obs, 1'b0, clr, `PLLSP_SEL_FUNC};
  endfunction
  // one frame; latches must still hold 100 cycles after the data write, then only the addressed one moves, the function latch for an init word
  task automatic send(input pllsp_pkg::pllsp_word_t w, input logic exp_irq);
    logic [31:0] q;
    int i;
    wb(`PLLSP_ADR_DATA, 1'b1, {11'h000, w}, q);
    repeat (100) @(posedge clk_sys);
    check({1'b0, ref_l, fb_l, fn_l}, {1'b0, exp_ref, exp_fb, exp_fn});
    for (i = 0; i < 600 && pllsp_if_i.load_strobe !== 1'b1; i++) @(posedge clk_sys);
    if (i == 600) begin
      fails++;
      stop_test();
    end
    @(posedge clk_sys);
    check(irq, exp_irq);
    case (w[1:0])
      2'h0: exp_ref = w;
      2'h1: exp_fb = w;
      default: exp_fn = w;
    endcase
    q = 32'h0;
    for (i = 0; i < 100 && q[0] !== 1'b1; i++) wb(`PLLSP_ADR_STAT, 1'b0, 32'h0, q);
    if (i == 100) begin
      fails++;
      stop_test();
    end
    check({1'b0, ref_l, fb_l, fn_l}, {1'b0, exp_ref, exp_fb, exp_fn});
  endtask
  task automatic period(input int exp);
    int i, n;
    logic low_seen;
    for (i = 0; i < 400 && pllsp_if_i.observe_out !== 1'b1; i++) @(posedge clk_sys);
    low_seen = 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys);
      if (pllsp_if_i.observe_out === 1'b0) begin
        low_seen = 1'b1;
      end else if (low_seen) begin
        break;
      end
    end
    check(n + 1, exp);
  endtask
  task automatic wait_lock(input logic v);
    int i;
    for (i = 0; i < 3000 && lock_detect !== v; i++) @(posedge clk_sys);
    check(lock_detect, v);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] q;
    exp_ref = `PLLSP_REF_RST;
    exp_fb = `PLLSP_FB_RST;
    exp_fn = `PLLSP_FUNC_RST;
    check({1'b0, ref_l, fb_l, fn_l}, {1'b0, exp_ref, exp_fb, exp_fn});
    wb(`PLLSP_ADR_STAT, 1'b0, 32'h0, q);
    check(q, 32'h0);
    check({irq, pllsp_if_i.observe_oe_n, pllsp_if_i.observe_out}, 3'h0);
    $display("test reset done");
  endtask
  task automatic t_latches();
    logic [31:0] q;
    wb(`PLLSP_ADR_CTRL, 1'b1, 32'h0000_0401, q);
    wb(`PLLSP_ADR_CTRL, 1'b0, 32'h0, q);
    check({q, powered}, {32'h0000_0401, 1'b1});
    send({1'b1, 4'h0, 14'h3FFF, `PLLSP_SEL_REF}, 1'b0);
    send({1'b1, 13'h1FFF, 5'h1F, `PLLSP_SEL_FB}, 1'b0);
    send(fw(3'h3, 1'b0), 1'b0);
    check({pllsp_if_i.observe_out, pllsp_if_i.observe_oe_n}, 2'h2);
    send(fw(3'h6, 1'b0), 1'b0);
    check(pllsp_if_i.observe_out, 1'b1);
    send({14'h0000, 3'h0, 2'h0, `PLLSP_SEL_INIT}, 1'b0);
    check(pllsp_if_i.observe_out, 1'b0);
    $display("test latches done");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wb(`PLLSP_ADR_MASK, 1'b1, 32'h1, q);
    send(fw(3'h0, 1'b0), 1'b1);
    @(posedge clk_sys);
    @(posedge clk_sys);
    check(irq, 1'b0);
    wb(`PLLSP_ADR_MASK, 1'b1, 32'h0, q);
    $display("test irq done");
  endtask
  task automatic t_divide();
    send(fw(3'h0, 1'b1), 1'b0);
    send({1'b0, 4'h0, 14'd98, `PLLSP_SEL_REF}, 1'b0);
    send({1'b0, 13'd3, 5'd2, `PLLSP_SEL_FB}, 1'b0);
    ref_in <= 1'b1;
    rf_in <= 1'b1;
    send(fw(3'h4, 1'b0), 1'b0);
    period(98);
    send(fw(3'h2, 1'b0), 1'b0);
    period(98);
    send(fw(3'h1, 1'b0), 1'b0);
    wait_lock(1'b1);
    check(pllsp_if_i.observe_out, 1'b1);
    send(fw(3'h5, 1'b0), 1'b0);
    check({pllsp_if_i.observe_oe_n, pllsp_if_i.observe_out}, 2'h2);
    send({1'b0, 13'd3, 5'd3, `PLLSP_SEL_FB}, 1'b0);
    wait_lock(1'b0);
    $display("test divide done");
  endtask
  task automatic t_power();
    logic [31:0] q;
    wb(`PLLSP_ADR_CTRL, 1'b1, 32'h0000_0400, q);
    @(posedge clk_sys);
    @(posedge clk_sys);
    check({pllsp_if_i.chip_enable, powered, pump_oe_n}, 3'h1);
    $display("test power done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    srst = 1'b1;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    wb_sel = 4'hF;
    {wb_we, wb_cyc, wb_stb, ref_in, rf_in} = 5'h00;
    fails = 0;
    compares = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_latches();
    t_irq();
    t_divide();
    t_power();
    stop_test();
  end
endmodule
